// File: inc/sarc_consts.svh
// register offsets, field positions, reset values and codes of the converter control block
// assumes a 32-bit axi4-lite slave with one aligned word per register
`ifndef SARC_CONSTS_SVH
`define SARC_CONSTS_SVH

// byte offsets inside the block window
`define SARC_ADDR_W 8
`define SARC_OFF_CTRL 8'h00
`define SARC_OFF_CHAN 8'h04
`define SARC_OFF_RES 8'h08
`define SARC_OFF_AOUT 8'h0c
`define SARC_OFF_STAT 8'h10

// control register layout
`define SARC_CTRL_RST 16'h0600
`define SARC_CTRL_MASK 16'h3fff
`define SARC_B_TEMP 13
`define SARC_B_EN 7
`define SARC_B_BUSYPIN 6
`define SARC_B_PWR 5
`define SARC_MODE_HI 4
`define SARC_MODE_LO 3
`define SARC_TYPE_HI 2
`define SARC_TYPE_LO 0

// channel select width and reset
`define SARC_CHAN_W 5
`define SARC_CHAN_RST 5'h00

// result word layout
`define SARC_RES_LSB 16
`define SARC_RES_MSB 27
`define SARC_SIGN_LSB 28
`define SARC_RES_W 12
`define SARC_WORD_RST 32'h00000000

// status bits
`define SARC_S_BUSY 0
`define SARC_S_RDY 1
`define SARC_S_CONT 2

// bus responses
`define SARC_RESP_OKAY 2'b00
`define SARC_RESP_SLVERR 2'b10

`endif

// File: inc/sarc_pkg.sv
// types shared by the converter control block
// assumes sarc_consts.svh supplies the numeric layout
package sarc_pkg;
    // input configuration, encoded as stored in the control register
    typedef enum logic [1:0] {
        SARC_SE = 2'b00,
        SARC_DIFF = 2'b01,
        SARC_PSEUDO = 2'b10
    } sarc_mode_t;

    // conversion start source selection
    typedef enum logic [2:0] {
        SARC_T_EXT = 3'b000,
        SARC_T_TMR0 = 3'b001,
        SARC_T_TMR1 = 3'b010,
        SARC_T_SINGLE = 3'b011,
        SARC_T_CONT = 3'b100,
        SARC_T_PLA = 3'b101
    } sarc_trig_t;

    // sequencer states, gray along idle, fire, wait
    typedef enum logic [1:0] {
        SARC_ST_IDLE = 2'b00,
        SARC_ST_FIRE = 2'b01,
        SARC_ST_WAIT = 2'b11
    } sarc_state_t;
endpackage

// File: hw/sarc_fmt.sv
// result formatter: packs a raw 12-bit converter code into the 32-bit data word
// assumes the raw code is twos complement in differential mode, straight binary otherwise
`include "sarc_consts.svh"

module sarc_fmt (
    input wire sarc_pkg::sarc_mode_t mode,
    input wire logic [11:0] raw,
    output logic [31:0] word
);
    import sarc_pkg::*;

    wire diff = (mode == SARC_DIFF); // twos complement path
    wire sign = diff & raw[11]; // straight binary is never negative
    // differential code moves right by one so the word reads as a signed integer
    wire [11:0] field = diff ? {raw[11], raw[11:1]} : raw; // see [RQ6] see [RQ7] see [RQ5]

    // sign copies on top, field in the middle, low half zero
    assign word = {{4{sign}}, field, 16'h0000}; // see [RQ9] see [RQ10]
endmodule // sarc_fmt

// File: hw/sarc_top.sv
// converter control and result formatting with an axi4-lite register slave
// assumes an analog core that answers each start pulse with one done pulse and a raw code
// Operation
// [RQ1] three input configurations, software selected
// [RQ2] software single or continuous conversions
// [RQ3] pin, logic array or timer triggers
// [RQ4] temperature channel selectable as input
// [RQ5] single-ended and pseudo results straight binary
// [RQ6] differential results in twos complement
// [RQ7] differential result shifted right by one
// [RQ8] completed conversion lands in result register
// [RQ9] result field at bits 16 to 27
// [RQ10] top four bits copy the sign
// [RQ11] analog output register shares result layout
// [RQ12] result holds until next completion, atomic
// [RQ13] mode field bits 4:3 picks configuration
// [RQ14] bit 7 gates starts, continuous keeps running
// [RQ15] software powers converter 5 us first
// [RQ16] bit 13 selects temperature conversions
//
// Implementation choices: the address map and register access over AXI4-Lite.
`include "sarc_consts.svh"

module sarc_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic ext_start_n,
    input wire logic pla_trig,
    input wire logic tmr0_ovf,
    input wire logic tmr1_ovf,
    output logic core_start,
    input wire logic core_done,
    input wire logic [11:0] core_result,
    output logic core_power,
    output sarc_pkg::sarc_mode_t core_mode,
    output logic core_temp,
    output logic [4:0] core_chan,
    output logic busy_pin,
    output logic [11:0] aout_code
);
    import sarc_pkg::*;

    // address known to the decoder
    function automatic logic sarc_known(input logic [7:0] a);
        sarc_known = (a == `SARC_OFF_CTRL) || (a == `SARC_OFF_CHAN) || (a == `SARC_OFF_RES)
            || (a == `SARC_OFF_AOUT) || (a == `SARC_OFF_STAT);
    endfunction

    // byte-lane merge of a write into an old word
    function automatic logic [31:0] sarc_merge(input logic [31:0] o, input logic [31:0] n,
                                               input logic [3:0] s);
        for (int i = 0; i < 4; i++) begin
            sarc_merge[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
        end
    endfunction

    // bus slave state
    logic aw_have_q, w_have_q; // captured address and data
    logic [7:0] aw_addr_q; // held write address
    logic [31:0] w_data_q; // held write data
    logic [3:0] w_strb_q; // held strobes
    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;

    // block registers
    logic [15:0] ctrl_q; // control register
    logic [4:0] chan_q; // channel select
    logic [31:0] result_q; // formatted result word
    logic [11:0] aout_q; // analog output code
    logic rdy_q; // result not yet read
    logic cont_q; // continuous run active
    logic sw_req_q; // software single request, one cycle
    logic ext_n_q, pla_q, tmr0_q, tmr1_q; // previous trigger levels
    sarc_state_t state_q; // sequencer
    sarc_mode_t mode_q; // configuration of the running conversion
    logic start_q; // start pulse to the core
    logic busy_pin_q; // busy indicator pin

    // handshakes
    wire aw_take = awvalid & awready_q;
    wire w_take = wvalid & wready_q;
    wire do_write = aw_have_q & w_have_q & ~bvalid_q; // both halves held
    wire ar_take = arvalid & arready_q;
    wire aw_have_d = (aw_have_q | aw_take) & ~do_write;
    wire w_have_d = (w_have_q | w_take) & ~do_write;
    wire bvalid_d = do_write | (bvalid_q & ~bready);
    wire rvalid_d = ar_take | (rvalid_q & ~rready);

    // write decode
    wire wr_ctrl = do_write & (aw_addr_q == `SARC_OFF_CTRL);
    wire wr_chan = do_write & (aw_addr_q == `SARC_OFF_CHAN);
    wire wr_aout = do_write & (aw_addr_q == `SARC_OFF_AOUT);
    wire [31:0] ctrl_merged = sarc_merge({16'h0000, ctrl_q}, w_data_q, w_strb_q);
    wire [31:0] chan_merged = sarc_merge({27'h0, chan_q}, w_data_q, w_strb_q);
    wire [31:0] aout_merged = sarc_merge({4'h0, aout_q, 16'h0000}, w_data_q, w_strb_q);
    wire [15:0] ctrl_new = ctrl_merged[15:0] & `SARC_CTRL_MASK;
    wire sarc_trig_t type_new = sarc_trig_t'(ctrl_new[`SARC_TYPE_HI:`SARC_TYPE_LO]);
    wire en_new = ctrl_new[`SARC_B_EN];

    // live control fields
    wire sarc_trig_t trig_type = sarc_trig_t'(ctrl_q[`SARC_TYPE_HI:`SARC_TYPE_LO]);
    wire start_ok = ctrl_q[`SARC_B_EN] & ctrl_q[`SARC_B_PWR]; // see [RQ14] see [RQ15]

    // hardware trigger edges, pins taken as synchronous
    wire ext_fall = ext_n_q & ~ext_start_n;
    wire pla_rise = ~pla_q & pla_trig;
    wire tmr0_rise = ~tmr0_q & tmr0_ovf;
    wire tmr1_rise = ~tmr1_q & tmr1_ovf;
    wire hw_edge = (trig_type == SARC_T_EXT && ext_fall) // see [RQ3]
        || (trig_type == SARC_T_PLA && pla_rise)
        || (trig_type == SARC_T_TMR0 && tmr0_rise)
        || (trig_type == SARC_T_TMR1 && tmr1_rise);

    // a new conversion begins only from idle; continuous runs ignore the enable
    wire launch = (state_q == SARC_ST_IDLE) && (cont_q || (start_ok && (sw_req_q || hw_edge)));
    wire finish = (state_q == SARC_ST_WAIT) && core_done;

    // formatted view of the finishing conversion
    logic [31:0] fmt_word;
    sarc_fmt u_fmt (
        .mode(mode_q),
        .raw(core_result),
        .word(fmt_word)
    );

    // read mux
    wire [31:0] rd_word = (araddr == `SARC_OFF_CTRL) ? {16'h0000, ctrl_q} :
        (araddr == `SARC_OFF_CHAN) ? {27'h0, chan_q} :
        (araddr == `SARC_OFF_RES) ? result_q :
        (araddr == `SARC_OFF_AOUT) ? {4'h0, aout_q, 16'h0000} : // see [RQ11]
        (araddr == `SARC_OFF_STAT) ? {29'h0, cont_q, rdy_q, state_q != SARC_ST_IDLE} :
        `SARC_WORD_RST;
    wire rd_res = ar_take & (araddr == `SARC_OFF_RES);

    // write channel capture and response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= `SARC_RESP_OKAY;
            aw_addr_q <= 8'h00;
            w_data_q <= `SARC_WORD_RST;
            w_strb_q <= 4'h0;
        end else begin
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            awready_q <= ~aw_have_d; // one write outstanding at a time
            wready_q <= ~w_have_d;
            bvalid_q <= bvalid_d;
            if (aw_take) begin
                aw_addr_q <= awaddr;
            end
            if (w_take) begin
                w_data_q <= wdata;
                w_strb_q <= wstrb;
            end
            if (do_write) begin
                bresp_q <= sarc_known(aw_addr_q) ? `SARC_RESP_OKAY : `SARC_RESP_SLVERR;
            end
        end
    end

    // read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= `SARC_WORD_RST;
            rresp_q <= `SARC_RESP_OKAY;
        end else begin
            arready_q <= ~rvalid_d;
            rvalid_q <= rvalid_d;
            if (ar_take) begin
                rdata_q <= rd_word;
                rresp_q <= sarc_known(araddr) ? `SARC_RESP_OKAY : `SARC_RESP_SLVERR;
            end
        end
    end

    // configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= `SARC_CTRL_RST;
            chan_q <= `SARC_CHAN_RST;
            aout_q <= 12'h000;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= ctrl_new; // see [RQ13] see [RQ16] see [RQ1]
            end
            if (wr_chan) begin
                chan_q <= chan_merged[4:0];
            end
            if (wr_aout) begin
                aout_q <= aout_merged[`SARC_RES_MSB:`SARC_RES_LSB]; // see [RQ11]
            end
        end
    end

    // software requests: single is a one-cycle request, continuous a held run
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sw_req_q <= 1'b0;
            cont_q <= 1'b0;
        end else begin
            sw_req_q <= wr_ctrl && en_new && type_new == SARC_T_SINGLE; // see [RQ2]
            if (wr_ctrl) begin
                // dropping the enable alone leaves a running series alone
                if (type_new != SARC_T_CONT) begin
                    cont_q <= 1'b0;
                end else if (en_new && ctrl_new[`SARC_B_PWR]) begin
                    cont_q <= 1'b1; // see [RQ2] see [RQ14]
                end
            end
        end
    end

    // trigger history for edge detection
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_n_q <= 1'b1;
            pla_q <= 1'b0;
            tmr0_q <= 1'b0;
            tmr1_q <= 1'b0;
        end else begin
            ext_n_q <= ext_start_n;
            pla_q <= pla_trig;
            tmr0_q <= tmr0_ovf;
            tmr1_q <= tmr1_ovf;
        end
    end

    // sequencer: fire a one-cycle start, then wait for the core
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= SARC_ST_IDLE;
            start_q <= 1'b0;
            mode_q <= SARC_SE;
        end else begin
            start_q <= launch;
            case (state_q)
                SARC_ST_IDLE: begin
                    if (launch) begin
                        state_q <= SARC_ST_FIRE;
                        // freeze the configuration so a mid-run write cannot skew the format
                        mode_q <= sarc_mode_t'(ctrl_q[`SARC_MODE_HI:`SARC_MODE_LO]); // see [RQ1]
                    end
                end
                SARC_ST_FIRE: begin
                    state_q <= SARC_ST_WAIT;
                end
                SARC_ST_WAIT: begin
                    if (core_done) begin
                        state_q <= SARC_ST_IDLE;
                    end
                end
                default: begin
                    state_q <= SARC_ST_IDLE;
                end
            endcase
        end
    end

    // result word and its ready flag; a completion beats a read clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            result_q <= `SARC_WORD_RST;
            rdy_q <= 1'b0;
            busy_pin_q <= 1'b0;
        end else begin
            if (finish) begin
                result_q <= fmt_word; // see [RQ8] see [RQ12]
            end
            rdy_q <= finish | (rdy_q & ~rd_res);
            busy_pin_q <= ctrl_q[`SARC_B_BUSYPIN] & (launch | (state_q != SARC_ST_IDLE & ~finish));
        end
    end

    // outputs
    assign awready = awready_q;
    assign wready = wready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign core_start = start_q;
    assign core_power = ctrl_q[`SARC_B_PWR];
    assign core_mode = sarc_mode_t'(ctrl_q[`SARC_MODE_HI:`SARC_MODE_LO]); // see [RQ13]
    assign core_temp = ctrl_q[`SARC_B_TEMP]; // see [RQ4] see [RQ16]
    assign core_chan = chan_q;
    assign busy_pin = busy_pin_q;
    assign aout_code = aout_q;

    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_start_pulse;
        core_start |=> !core_start && state_q == SARC_ST_WAIT;
    endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("start not one cycle"); // [RQ2]

    property p_res_load;
        finish |=> result_q == $past(fmt_word);
    endproperty
    a_res_load: assert property (p_res_load) else $error("result not loaded"); // [RQ8]

    property p_res_hold;
        !finish |=> $stable(result_q);
    endproperty
    a_res_hold: assert property (p_res_hold) else $error("result changed early"); // [RQ12]

    property p_sign_copy;
        // straight binary keeps a clear top nibble even when bit 27 is set
        (result_q[31:`SARC_SIGN_LSB] == 4'h0 || (result_q[31:`SARC_SIGN_LSB] == 4'hf
            && result_q[`SARC_RES_MSB])) && result_q[15:0] == 16'h0000;
    endproperty
    a_sign_copy: assert property (p_sign_copy) else $error("sign bits wrong"); // [RQ10]

    property p_diff_fmt;
        finish && mode_q == SARC_DIFF
            |=> result_q[31:16] == {{5{$past(core_result[11])}}, $past(core_result[11:1])};
    endproperty
    a_diff_fmt: assert property (p_diff_fmt) else $error("differential shift wrong"); // [RQ7]

    property p_bin_fmt;
        finish && mode_q != SARC_DIFF
            |=> result_q[27:16] == $past(core_result) && result_q[31:28] == 4'h0;
    endproperty
    a_bin_fmt: assert property (p_bin_fmt) else $error("binary result wrong"); // [RQ5]

    property p_no_start_disabled;
        state_q == SARC_ST_IDLE && !ctrl_q[`SARC_B_EN] && !cont_q |=> !core_start;
    endproperty
    a_no_start_disabled: assert property (p_no_start_disabled) else $error("bad start"); // [RQ14]

    property p_cont_rerun;
        finish && cont_q ##1 cont_q |=> core_start;
    endproperty
    a_cont_rerun: assert property (p_cont_rerun) else $error("continuous run stalled"); // [RQ2]

    property p_ext_trig;
        state_q == SARC_ST_IDLE && start_ok && trig_type == SARC_T_EXT && ext_n_q && !ext_start_n
            |=> core_start ##1 state_q == SARC_ST_WAIT;
    endproperty
    a_ext_trig: assert property (p_ext_trig) else $error("pin trigger missed"); // [RQ3]

    property p_mode_cap;
        launch |=> mode_q == $past(core_mode);
    endproperty
    a_mode_cap: assert property (p_mode_cap) else $error("mode not captured"); // [RQ13]

    property p_bresp_hold;
        bvalid && !bready |=> bvalid && $stable(bresp);
    endproperty
    a_bresp_hold: assert property (p_bresp_hold) else $error("write response dropped");

    c_cont: cover property (finish && cont_q ##2 core_start);
    c_diff: cover property (finish && mode_q == SARC_DIFF && core_result[11]);
    c_ext: cover property (ext_fall && launch);
    c_err: cover property (bvalid && bresp == `SARC_RESP_SLVERR);
endmodule // sarc_top

// File: verif/sarc_core_model.sv
// behavioural analog core that answers each start pulse with one done pulse and a raw code
// assumes the bench sets the answer delay (at least 1) and the raw code before each start
module sarc_core_model (
    input wire logic aclk,
    input wire logic core_start,
    input wire logic [7:0] delay,
    input wire logic [11:0] code,
    output logic core_done,
    output logic [11:0] core_result
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0; // cycles left in the running conversion
    initial core_done = 1'b0;
    initial core_result = 12'h000;
    // done pulses once per start; the code is only valid with done, so it
    // toggles otherwise and a stale sample of it shows up as a wrong result
    always @(posedge aclk) begin
        core_done <= 1'b0;
        core_result <= ~core_result;
        if (core_start) begin
            cnt <= delay;
        end else if (cnt == 1) begin
            core_done <= 1'b1;
            core_result <= code;
            cnt <= 0;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
endmodule // sarc_core_model

// File: verif/sar_adc_control_result_format_tb.sv
// self-checking bench of the converter control block, driven over axi4-lite
// assumes the core model answers starts; trigger sources are driven by the bench
`include "sarc_consts.svh"

module sar_adc_control_result_format_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import sarc_pkg::*;
    // one row: configuration, raw core code and the data word it must give
    typedef struct packed {
        logic [1:0] mode;
        logic temp;
        logic [11:0] raw;
        logic [31:0] word;
    } sarc_row_t;
    sarc_row_t rows [7] = '{
        '{2'h0, 1'h0, 12'habc, 32'h0abc0000},
        '{2'h2, 1'h0, 12'hfff, 32'h0fff0000},
        '{2'h1, 1'h0, 12'h800, 32'hfc000000},
        '{2'h1, 1'h0, 12'h7fe, 32'h03ff0000},
        '{2'h1, 1'h1, 12'h003, 32'h00010000},
        '{2'h1, 1'h0, 12'hfff, 32'hffff0000},
        '{2'h0, 1'h1, 12'h5a5, 32'h05a50000}
    };
    logic [2:0] tt [4] = '{3'h0, 3'h1, 3'h2, 3'h5}; // pin, first_general_timer, second_general_timer, logic array
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, delay = 8'h03;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'hf;
    logic [3:0] trg = 4'h0; // trigger sources, active high here
    logic awready, wready, bvalid, arready, rvalid, core_start, core_done;
    logic core_power, core_temp, busy_pin;
    logic [1:0] bresp, rresp;
    logic [11:0] core_result, aout_code, code = 12'h000;
    logic [4:0] core_chan;
    sarc_mode_t core_mode;
    int n_errors = 0, checks_done = 0, n_starts = 0, cyc = 0;

    sarc_top uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .ext_start_n(~trg[0]), .pla_trig(trg[3]),
        .tmr0_ovf(trg[1]), .tmr1_ovf(trg[2]), .core_start(core_start),
        .core_done(core_done), .core_result(core_result), .core_power(core_power),
        .core_mode(core_mode), .core_temp(core_temp), .core_chan(core_chan),
        .busy_pin(busy_pin), .aout_code(aout_code));
    sarc_core_model u_core (.aclk(aclk), .core_start(core_start), .delay(delay),
        .code(code), .core_done(core_done), .core_result(core_result));

    initial begin
        forever #25 aclk = ~aclk;
    end

    // cycle count for the hang limit, and a tally of conversion starts
    always @(posedge aclk) begin
        cyc++;
        if (core_start === 1'b1) n_starts++;
        if (cyc == 5000) begin
            n_errors++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        if (n_errors == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one write; the leading edge lets the previous release land first
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (awvalid && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1) @(posedge aclk);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge aclk);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic wc(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        wr(a, d, r);
        chk("write resp", 32'h0, {30'h0, r});
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(what, exp, d);
        chk("read resp", 32'h0, {30'h0, r});
    endtask

    // polls status until a result is ready; bounded so a lost done cannot hang
    task automatic wait_rdy();
        logic [31:0] d;
        logic [1:0] r;
        int n;
        d = 32'h0;
        n = 0;
        while (d[`SARC_S_RDY] !== 1'b1 && n < 100) begin
            rd(`SARC_OFF_STAT, d, r);
            n++;
        end
        chk("ready flag", 32'h1, {31'h0, d[`SARC_S_RDY]});
    endtask

    task automatic pulse(input int k);
        trg[k] <= 1'b1;
        @(posedge aclk);
        trg[k] <= 1'b0;
    endtask

    initial begin
        logic [31:0] d;
        logic [1:0] r;
        int n0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(`SARC_OFF_CTRL, 32'h00000600, "ctrl reset");
        rchk(`SARC_OFF_RES, 32'h0, "result reset");
        wc(`SARC_OFF_CTRL, 32'h0020);
        chk("power", 32'h1, {31'h0, core_power});
        repeat (100) @(posedge aclk);
        wc(`SARC_OFF_CHAN, 32'h1f);
        chk("channel", 32'h1f, {27'h0, core_chan});
        // table: every configuration, sign boundaries and the temperature channel
        for (int i = 0; i < 7; i++) begin
            code <= rows[i].raw;
            wc(`SARC_OFF_CTRL,
                32'h00a3 | {rows[i].temp, 13'h0} | {rows[i].mode, 3'h0});
            chk("mode", {30'h0, rows[i].mode}, {30'h0, core_mode});
            chk("temp", {31'h0, rows[i].temp}, {31'h0, core_temp});
            wait_rdy();
            rchk(`SARC_OFF_RES, rows[i].word,
                "result");
        end
        // a slow conversion: the old word must stand until the new one lands
        delay <= 8'h28;
        code <= 12'h123;
        wc(`SARC_OFF_CTRL, 32'h00e3);
        rchk(`SARC_OFF_RES, rows[6].word, "held result");
        chk("busy pin", 32'h1, {31'h0, busy_pin});
        wait_rdy();
        rchk(`SARC_OFF_RES, 32'h01230000, "new result");
        delay <= 8'h03;
        // each outside trigger source starts exactly one conversion
        foreach (tt[k]) begin
            wc(`SARC_OFF_CTRL, 32'h00a0 | tt[k]);
            n0 = n_starts;
            pulse(k);
            repeat (12) @(posedge aclk);
            chk("trigger start", n0 + 1, n_starts);
        end
        // enable cleared, then an unselected source: neither may start
        n0 = n_starts;
        wc(`SARC_OFF_CTRL, 32'h0021);
        pulse(1);
        wc(`SARC_OFF_CTRL, 32'h00a1);
        pulse(2);
        repeat (12) @(posedge aclk);
        chk("blocked start", n0, n_starts);
        // continuous series survives clearing the enable, stops on another type
        wc(`SARC_OFF_CTRL, 32'h00a4);
        n0 = n_starts;
        repeat (40) @(posedge aclk);
        chk("continuous", 32'h1, {31'h0, n_starts > n0 + 4});
        wc(`SARC_OFF_CTRL, 32'h0024);
        n0 = n_starts;
        repeat (40) @(posedge aclk);
        chk("continuous kept", 32'h1, {31'h0, n_starts > n0 + 4});
        wc(`SARC_OFF_CTRL, 32'h0023);
        repeat (10) @(posedge aclk);
        n0 = n_starts;
        repeat (40) @(posedge aclk);
        chk("continuous off", n0, n_starts);
        // analog output word shares the result layout
        wc(`SARC_OFF_AOUT, 32'hfabc1234);
        chk("aout code", 32'h0abc, {20'h0, aout_code});
        rchk(`SARC_OFF_AOUT, 32'h0abc0000, "aout readback");
        // unmapped address answers with an error and no data
        wr(8'h20, 32'h1, r);
        chk("bad write resp", 32'h2, {30'h0, r});
        rd(8'h20, d, r);
        chk("bad read data", 32'h0, d);
        chk("bad read resp", 32'h2, {30'h0, r});
        // reset with the sequencer idle: registers and outputs fall back to their reset values
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        chk("power after reset", 32'h0, {31'h0, core_power});
        chk("aout after reset", 32'h0, {20'h0, aout_code});
        chk("busy after reset", 32'h0, {31'h0, busy_pin});
        rchk(`SARC_OFF_CTRL, 32'h00000600, "ctrl after reset");
        rchk(`SARC_OFF_RES, 32'h0, "result after reset");
        print_verdict();
    end
endmodule // sar_adc_control_result_format_tb
